/* rtl/analog_input_scan_control.sv */
`timescale 1ns/1ns
`default_nettype none
module analog_input_scan_control
  import ai_scan_pkg::*;
#(
  parameter int NormCycles = NORM_CYC,
  parameter int FiltCycles = FILT_CYC
) (
  input  wire logic        core_clk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [3:0]  unitSw,
  input  wire logic        cntSwA,
  input  wire logic        cntSwB,
  input  wire logic        rangeSw,
  input  wire logic        modeSw,
  input  wire logic        adcDone,
  input  wire logic [11:0] adcData,
  input  wire logic        adcWireOpen,
  output logic             adcReq,
  output logic      [1:0]  adcChan,
  output logic             runLamp,
  output logic             wireBreakLamp
);
  // =====================================
  // pin synchronisers
  logic [21:0] pinRaw;
  logic [21:0] pinMeta_q;
  logic [21:0] pinSync_q;
  logic [3:0]  unitPin;
  logic [1:0]  cntPin;
  logic        rangePin;
  logic        modePin;
  logic        doneSync;
  logic [11:0] dataSync;
  logic        wireSync;

  assign pinRaw = {adcWireOpen, adcData, adcDone, modeSw, rangeSw,
                   cntSwB, cntSwA, unitSw};

  // every pin is asynchronous, two stages before any use
  always_ff @(posedge core_clk) begin
    if (reset) begin
      pinMeta_q <= 22'h00_0000;
      pinSync_q <= 22'h00_0000;
    end else begin
      pinMeta_q <= pinRaw;
      pinSync_q <= pinMeta_q;
    end
  end

  // data settles before done rises, so one shared stage pair suffices
  assign unitPin  = pinSync_q[3:0];
  assign cntPin   = {pinSync_q[4], pinSync_q[5]};
  assign rangePin = pinSync_q[6];
  assign modePin  = pinSync_q[7];
  assign doneSync = pinSync_q[8];
  assign dataSync = pinSync_q[20:9];
  assign wireSync = pinSync_q[21];

  // =====================================
  // register bus signals
  logic        access;
  logic        wrHit;
  logic        restartHit;
  logic        mapped;
  logic [31:0] rdVal;
  logic [31:0] prdata_q;
  logic [15:0] ctrl_q;
  value_t      scaleLo_q;
  value_t      scaleHi_q;
  logic [1:0]  meanLog2_q;
  logic [CHANNELS-1:0][15:0] res_q;

  assign access = psel && penable;
  assign wrHit  = access && pwrite;
  // one restart flag for this unit, write one to fire
  assign restartHit = wrHit && paddr == ADDR_RESTART && pwdata[0];

  // =====================================
  // switch capture at reset release or restart
  logic [1:0] load_q;
  logic [3:0] unit_q;
  logic [1:0] cnt_q;
  logic       range_q;
  logic       filter_q;

  // a few cycles let the synchronisers fill after release
  always_ff @(posedge core_clk) begin
    if (reset || restartHit) begin
      load_q <= LOAD_WAIT;
    end else if (load_q != 2'h0) begin
      load_q <= load_q - 2'h1;
    end
  end

  // switches moved while running are ignored until the next load
  always_ff @(posedge core_clk) begin
    if (reset) begin
      unit_q   <= UNIT_RST;
      cnt_q    <= 2'h0;
      range_q  <= 1'b0;
      filter_q <= 1'b0;
    end else if (load_q == 2'h1) begin
      unit_q   <= (unitPin > UNIT_MAX) ? UNIT_RST : unitPin;
      cnt_q    <= cntPin;
      range_q  <= rangePin;
      filter_q <= modePin;
    end
  end

  // =====================================
  // channel count decode
  logic [1:0] lastChan;
  logic [1:0] cntField;
  logic       setErr;
  logic       ready;

  always_comb begin
    lastChan = 2'h0;
    cntField = 2'h0;
    setErr   = 1'b0;
    case (cnt_q)
      2'b01: begin
        lastChan = 2'h0;
        cntField = 2'b10;
      end
      2'b10: begin
        lastChan = 2'h1;
        cntField = 2'b01;
      end
      2'b00: begin
        lastChan = 2'h3;
        cntField = 2'b00;
      end
      default: begin
        setErr = 1'b1;
      end
    endcase
  end

  assign ready = load_q == 2'h0 && !setErr;

  // =====================================
  // scan sequencer
  scan_state_t state_q;
  scan_state_t state_d;
  logic [1:0]  chan_q;
  logic [1:0]  take_q;
  logic [1:0]  need;
  value_t      sum_q;
  logic        wire_q;
  logic [19:0] tmo_q;
  logic [19:0] tmoLast;
  logic        timeout;
  logic [30:0] prod3;
  logic [11:0] avg;
  logic        procFire;

  assign need     = filter_q ? FILT_TAKES : NORM_TAKES;
  assign tmoLast  = filter_q ? 20'(FiltCycles - 1) : 20'(NormCycles - 1);
  assign timeout  = (state_q == ST_REQ || state_q == ST_REL)
                    && tmo_q == tmoLast;
  assign procFire = state_q == ST_PROC;

  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (ready && !ctrl_q[CTL_INH]) state_d = ST_REQ;
      end
      ST_REQ: begin
        if (timeout) state_d = ST_HALT;
        else if (doneSync) state_d = ST_REL;
      end
      ST_REL: begin
        if (timeout) state_d = ST_HALT;
        else if (!doneSync) state_d = (take_q == need) ? ST_PROC : ST_REQ;
      end
      ST_PROC: begin
        state_d = ST_IDLE;
      end
      ST_HALT: begin
        state_d = ST_HALT;
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
    // only a restart or reset leaves the halted state
    if (restartHit) state_d = ST_IDLE;
  end

  always_ff @(posedge core_clk) begin
    if (reset) state_q <= ST_IDLE;
    else state_q <= state_d;
  end

  // per-channel time budget, counts only while waiting on the converter
  always_ff @(posedge core_clk) begin
    if (reset || state_q == ST_IDLE) tmo_q <= 20'h0_0000;
    else if (state_q == ST_REQ || state_q == ST_REL) tmo_q <= tmo_q + 20'h0_0001;
  end

  // sample gathering, three takes summed in filter mode
  always_ff @(posedge core_clk) begin
    if (reset || state_q == ST_IDLE) begin
      take_q <= 2'h0;
      sum_q  <= 14'h0000;
      wire_q <= 1'b0;
    end else if (state_q == ST_REQ && doneSync) begin
      take_q <= take_q + 2'h1;
      sum_q  <= sum_q + {2'b00, dataSync};
      wire_q <= wire_q | wireSync;
    end
  end

  // divide by three as multiply and shift, exact up to three top codes
  assign prod3 = {17'h0_0000, sum_q} * {14'h0000, THIRD_MUL};
  assign avg   = filter_q ? prod3[27:16] : sum_q[11:0];

  // ascending channel walk, wraps after the last enabled one
  always_ff @(posedge core_clk) begin
    if (reset || restartHit) chan_q <= 2'h0;
    else if (procFire) chan_q <= (chan_q >= lastChan) ? 2'h0 : chan_q + 2'h1;
  end

  assign adcReq  = state_q == ST_REQ;
  assign adcChan = chan_q;

  // =====================================
  // wire break and lamps
  logic [CHANNELS-1:0] disc_q;
  logic                run_q;
  logic                lamp_q;

  // 0 to 10 V has no live zero, so an open wire cannot be told apart
  always_ff @(posedge core_clk) begin
    if (reset || restartHit) disc_q <= 4'h0;
    else if (procFire) disc_q[chan_q] <= !range_q && wire_q;
  end

  always_ff @(posedge core_clk) begin
    if (reset) begin
      run_q  <= 1'b0;
      lamp_q <= 1'b0;
    end else begin
      run_q  <= state_q != ST_HALT && ready;
      lamp_q <= |disc_q;
    end
  end

  assign runLamp       = run_q;
  assign wireBreakLamp = lamp_q;

  // =====================================
  // channel processing lanes
  proc_if pif [CHANNELS] (.clk(core_clk), .rst(reset));
  logic [CHANNELS-1:0][15:0] laneRes;
  logic [CHANNELS-1:0]       laneStb;

  for (genvar g = 0; g < CHANNELS; g++) begin : g_lane
    assign pif[g].sampleValid = procFire && chan_q == 2'(g);
    assign pif[g].sample      = avg;
    assign pif[g].sqrtEn      = ctrl_q[CTL_SRT];
    assign pif[g].scaleEn     = ctrl_q[CTL_SCL+g];
    assign pif[g].meanEn      = ctrl_q[CTL_AVG+g];
    assign pif[g].peakEn      = ctrl_q[CTL_PKE];
    assign pif[g].scaleLo     = scaleLo_q;
    assign pif[g].scaleHi     = scaleHi_q;
    assign pif[g].meanLog2    = meanLog2_q;
    assign pif[g].clear       = restartHit;
    assign laneRes[g]         = pif[g].result;
    assign laneStb[g]         = pif[g].resultValid;
    channel_proc u_proc (
      .p (pif[g])
    );
  end

  // result word follows its lane right after processing
  always_ff @(posedge core_clk) begin
    if (reset) begin
      res_q <= '0;
    end else begin
      for (int i = 0; i < CHANNELS; i++) begin
        if (laneStb[i]) res_q[i] <= laneRes[i];
      end
    end
  end

  // =====================================
  // apb registers
  always_ff @(posedge core_clk) begin
    if (reset) begin
      ctrl_q     <= CTRL_RST;
      scaleLo_q  <= SLO_RST;
      scaleHi_q  <= SHI_RST;
      meanLog2_q <= MEAN_RST;
    end else if (wrHit) begin
      case (paddr)
        ADDR_CTRL: ctrl_q    <= pwdata[15:0];
        ADDR_SLO:  scaleLo_q <= pwdata[13:0];
        ADDR_SHI:  scaleHi_q <= pwdata[13:0];
        ADDR_MEAN: meanLog2_q <= pwdata[1:0];
        default: begin
        end
      endcase
    end
  end

  // read mux; one register per address, unmapped addresses raise pslverr
  always_comb begin
    rdVal  = 32'h0000_0000;
    mapped = 1'b1;
    case (paddr)
      ADDR_CTRL: rdVal = {16'h0000, ctrl_q};
      ADDR_RES0: rdVal = {16'h0000, res_q[0]};
      ADDR_RES1: rdVal = {16'h0000, res_q[1]};
      ADDR_RES2: rdVal = {16'h0000, res_q[2]};
      ADDR_RES3: rdVal = {16'h0000, res_q[3]};
      ADDR_STAT: rdVal = {16'h0000, unit_q, 2'b00, run_q, 1'b0,
                          cntField, range_q, disc_q, setErr};
      ADDR_RESTART: rdVal = 32'h0000_0000;
      ADDR_MAP: rdVal = {4'h0, 12'(PARM_BASE0 + PARM_STEP * unit_q),
                         8'h00, 8'(HOST_BASE0 + HOST_STEP * unit_q)};
      ADDR_SLO:  rdVal = {18'h0_0000, scaleLo_q};
      ADDR_SHI:  rdVal = {18'h0_0000, scaleHi_q};
      ADDR_MEAN: rdVal = {30'h0000_0000, meanLog2_q};
      default:   mapped = 1'b0;
    endcase
  end

  // read data taken in the setup cycle so it is a flop during access
  always_ff @(posedge core_clk) begin
    if (reset) prdata_q <= 32'h0000_0000;
    else if (psel && !penable) prdata_q <= rdVal;
  end

  assign prdata  = prdata_q;
  assign pready  = 1'b1;
  assign pslverr = access && !mapped;

  // =====================================
  // checks
  sequence procStep;
    state_q == ST_PROC;
  endsequence

  sequence waitStep;
    state_q == ST_REQ || state_q == ST_REL;
  endsequence

  chk_timeout_halt: assert property (@(posedge core_clk) disable iff (reset)
    (waitStep and tmo_q == tmoLast) ##0 !restartHit |=> state_q == ST_HALT)
    else $error("no halt on conversion timeout");
  chk_halt_dark: assert property (@(posedge core_clk) disable iff (reset)
    state_q == ST_HALT |=> !runLamp && !adcReq)
    else $error("halted but lamp or request active");
  chk_wire_range: assert property (@(posedge core_clk) disable iff (reset)
    range_q [*2] |-> !wireBreakLamp)
    else $error("wire break lamp in 0 to 10 V range");
  chk_chan_bound: assert property (@(posedge core_clk) disable iff (reset)
    adcReq |-> adcChan <= lastChan)
    else $error("disabled channel converted");
  // filter takes re-raise the request mid-channel, so only idle starts count
  chk_inhibit_hold: assert property (@(posedge core_clk)
    disable iff (reset)
    $rose(adcReq) && $past(state_q) == ST_IDLE |-> !$past(ctrl_q[CTL_INH]))
    else $error("conversion started while inhibited");
  chk_filter_takes: assert property (@(posedge core_clk) disable iff (reset)
    procStep |-> take_q == (filter_q ? FILT_TAKES : NORM_TAKES))
    else $error("wrong number of samples");
  chk_scan_order: assert property (@(posedge core_clk) disable iff (reset)
    $changed(chan_q) |-> chan_q == 2'h0 || chan_q == $past(chan_q) + 2'h1)
    else $error("channel order broken");
  chk_unit_hold: assert property (@(posedge core_clk) disable iff (reset)
    load_q == 2'h0 && !restartHit |=> $stable(unit_q))
    else $error("unit number changed without restart");
endmodule : analog_input_scan_control
`default_nettype wire

/* rtl/ai_scan_pkg.sv */
`default_nettype none
package ai_scan_pkg;
  // =====================================
  // timing
  localparam int CLK_NS       = 4;
  localparam int NORM_TIME_NS = 2_500_000;
  localparam int FILT_TIME_NS = 4_000_000;
  localparam int NORM_CYC     = NORM_TIME_NS / CLK_NS;
  localparam int FILT_CYC     = FILT_TIME_NS / CLK_NS;
  localparam int CHANNELS     = 4;
  localparam logic [1:0]  FILT_TAKES = 2'h3;
  localparam logic [1:0]  NORM_TAKES = 2'h1;
  localparam logic [1:0]  LOAD_WAIT  = 2'h3;
  // =====================================
  // codes and mapping
  localparam logic [11:0] TOP_CODE  = 12'h0fa0;
  localparam logic [16:0] THIRD_MUL = 17'h0_5556;
  localparam logic [3:0]  UNIT_MAX  = 4'h9;
  localparam logic [3:0]  UNIT_RST  = 4'h0;
  localparam int HOST_BASE0 = 100;
  localparam int HOST_STEP  = 10;
  localparam int PARM_BASE0 = 1000;
  localparam int PARM_STEP  = 100;
  // =====================================
  // register map
  localparam logic [7:0] ADDR_CTRL    = 8'h00;
  localparam logic [7:0] ADDR_RES0    = 8'h04;
  localparam logic [7:0] ADDR_RES1    = 8'h08;
  localparam logic [7:0] ADDR_RES2    = 8'h0c;
  localparam logic [7:0] ADDR_RES3    = 8'h10;
  localparam logic [7:0] ADDR_STAT    = 8'h14;
  localparam logic [7:0] ADDR_RESTART = 8'h18;
  localparam logic [7:0] ADDR_MAP     = 8'h1c;
  localparam logic [7:0] ADDR_SLO     = 8'h20;
  localparam logic [7:0] ADDR_SHI     = 8'h24;
  localparam logic [7:0] ADDR_MEAN    = 8'h28;
  localparam int CTL_INH = 0;
  localparam int CTL_SCL = 2;
  localparam int CTL_AVG = 7;
  localparam int CTL_PKE = 11;
  localparam int CTL_SRT = 12;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [13:0] SLO_RST  = 14'h0000;
  localparam logic [13:0] SHI_RST  = 14'h0fa0;
  localparam logic [1:0]  MEAN_RST = 2'h0;
  typedef logic [13:0] value_t;
  typedef enum logic [2:0] {
    ST_IDLE, ST_REQ, ST_REL, ST_PROC, ST_HALT
  } scan_state_t;
endpackage : ai_scan_pkg
`default_nettype wire

/* rtl/proc_if.sv */
`timescale 1ns/1ns
`default_nettype none
interface proc_if (
  input wire logic clk,
  input wire logic rst
);
  logic                       sampleValid;
  logic [11:0]                sample;
  logic                       sqrtEn;
  logic                       scaleEn;
  logic                       meanEn;
  logic                       peakEn;
  ai_scan_pkg::value_t        scaleLo;
  ai_scan_pkg::value_t        scaleHi;
  logic [1:0]                 meanLog2;
  logic                       clear;
  logic [15:0]                result;
  logic                       resultValid;
  modport ctl (input clk, rst, result, resultValid,
    output sampleValid, sample, sqrtEn, scaleEn, meanEn, peakEn,
    scaleLo, scaleHi, meanLog2, clear);
  modport chan (input clk, rst, sampleValid, sample, sqrtEn, scaleEn,
    meanEn, peakEn, scaleLo, scaleHi, meanLog2, clear,
    output result, resultValid);
endinterface : proc_if
`default_nettype wire

/* rtl/channel_proc.sv */
`timescale 1ns/1ns
`default_nettype none
module channel_proc
  import ai_scan_pkg::*;
(
  proc_if.chan p
);
  // =====================================
  // arithmetic helpers
  function automatic logic [11:0] isqrt(input logic [23:0] x);
    logic [11:0] r;
    logic [11:0] t;
    logic [23:0] sq;
    r = 12'h000;
    for (int i = 11; i >= 0; i--) begin
      t = r | (12'h001 << i);
      sq = {12'h000, t} * {12'h000, t};
      if (sq <= x) r = t;
    end
    return r;
  endfunction : isqrt
  function automatic logic [15:0] toBcd(input value_t v);
    logic [29:0] s;
    s = {16'h0000, v};
    for (int i = 0; i < 14; i++) begin
      for (int d = 0; d < 4; d++) begin
        if (s[14+4*d +: 4] > 4'h4) s[14+4*d +: 4] += 4'h3;
      end
      s = s << 1;
    end
    return s[29:14];
  endfunction : toBcd
  // =====================================
  // per-sample chain
  value_t v1, v2, span, outVal, pkNext, meanOut, finalVal, peak_q;
  logic [27:0] prod, quot;
  logic [16:0] accSum, acc_q;
  logic [2:0]  cnt_q;
  logic        full, emit;
  always_comb begin
    // sqrt reported on the full code scale so it stays linear
    v1 = p.sqrtEn ? {2'b00, isqrt({12'h000, p.sample} *
      {12'h000, TOP_CODE})} : {2'b00, p.sample};
    span = (p.scaleHi >= p.scaleLo) ? p.scaleHi - p.scaleLo : 14'h0000;
    prod = {14'h0000, v1} * {14'h0000, span};
    quot = prod / {16'h0000, TOP_CODE};
    v2 = p.scaleEn ? p.scaleLo + quot[13:0] : v1;
    accSum = acc_q + {3'b000, v2};
    full = cnt_q == 3'((4'h1 << p.meanLog2) - 4'h1);
    meanOut = 14'(accSum >> p.meanLog2);
    emit = p.sampleValid && (!p.meanEn || full);
    outVal = p.meanEn ? meanOut : v2;
    pkNext = (outVal > peak_q) ? outVal : peak_q;
    finalVal = p.peakEn ? pkNext : outVal;
  end
  // mean accumulator, restarts when disabled
  always_ff @(posedge p.clk) begin
    if (p.rst || p.clear || !p.meanEn) begin
      acc_q <= 17'h0_0000;
      cnt_q <= 3'h0;
    end else if (p.sampleValid) begin
      acc_q <= full ? 17'h0_0000 : accSum;
      cnt_q <= full ? 3'h0 : cnt_q + 3'h1;
    end
  end
  // peak hold, forgotten when peak mode is off
  always_ff @(posedge p.clk) begin
    if (p.rst || p.clear || !p.peakEn) begin
      peak_q <= 14'h0000;
    end else if (emit) begin
      peak_q <= pkNext;
    end
  end
  // result word, bcd only when scaled
  always_ff @(posedge p.clk) begin
    if (p.rst) begin
      p.result      <= 16'h0000;
      p.resultValid <= 1'b0;
    end else begin
      p.resultValid <= emit;
      if (emit) p.result <= p.scaleEn ? toBcd(finalVal) : {2'b00, finalVal};
    end
  end
  chk_peak_rise: assert property (@(posedge p.clk) disable iff (p.rst)
    (p.peakEn && !p.clear) [*2] |-> peak_q >= $past(peak_q))
    else $error("peak value fell");
  chk_mean_wait: assert property (@(posedge p.clk) disable iff (p.rst)
    p.sampleValid && p.meanEn && !full |=> !p.resultValid)
    else $error("mean emitted early");
endmodule : channel_proc
`default_nettype wire

/* test/adc_model.sv */
`timescale 1ns/1ns
`default_nettype none
module adc_model (
  input  wire logic        clk,
  input  wire logic        req,
  input  wire logic [1:0]  chan,
  input  wire logic        stall,
  input  wire logic        openIn,
  output logic             done,
  output logic      [11:0] data,
  output logic             wireOpen
);
  // ========
  // converter answer
  // time-zero idle state of the answer lines
  initial begin
    done     = 1'b0;
    data     = 12'h0000;
    wireOpen = 1'b0;
  end
  // four-phase answer; stall models a dead converter that never replies
  always @(posedge clk) begin
    if (req && !done && !stall) begin
      done     <= 1'b1;
      data     <= {2'h0, chan, 8'h34}; // code per channel, below top
      wireOpen <= openIn;
    end else if (!req && done) begin
      done <= 1'b0;
      data <= ~data; // released: stale code must not be reused
    end
  end
endmodule : adc_model
`default_nettype wire

/* test/analog_input_scan_control_tb_top.sv */
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e) chk_val(32'(g), 32'(e))
module analog_input_scan_control_tb_top;
  import ai_scan_pkg::*;
  // ========
  // bench signals
  logic        core_clk, reset, psel, penable, pwrite, pready, pslverr;
  logic        cntSwA, cntSwB, rangeSw, modeSw, adcDone, adcWireOpen;
  logic        adcReq, runLamp, wireBreakLamp, stall, openIn, reqQ, slvErr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0]  unitSw;
  logic [11:0] adcData;
  logic [1:0]  adcChan;
  logic [1:0]  chanLog[$];
  int          err_total = 0;
  int          samples_checked = 0;

  // short limits keep the halt case quick
  analog_input_scan_control #(.NormCycles(200), .FiltCycles(300)) dut (
    .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .unitSw(unitSw),
    .cntSwA(cntSwA), .cntSwB(cntSwB), .rangeSw(rangeSw),
    .modeSw(modeSw), .adcDone(adcDone), .adcData(adcData),
    .adcWireOpen(adcWireOpen), .adcReq(adcReq), .adcChan(adcChan),
    .runLamp(runLamp), .wireBreakLamp(wireBreakLamp));
  adc_model adc (.clk(core_clk), .req(adcReq), .chan(adcChan),
    .stall(stall), .openIn(openIn), .done(adcDone), .data(adcData),
    .wireOpen(adcWireOpen));

  // ========
  // clock and request log
  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end
  // channel of every fresh request, in order
  always @(posedge core_clk) begin
    reqQ <= adcReq;
    if (adcReq && !reqQ) chanLog.push_back(adcChan);
  end

  // ========
  // helpers
  task automatic chk_val(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk_val
  task automatic end_sim();
    $display("checks=%0d mismatches=%0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_sim
  task automatic fail_wait();
    err_total++;
    $display("[FAIL] t=%0t wait got=%h exp=%h", $time, 1'b0, 1'b1);
    end_sim();
  endtask : fail_wait
  // one apb transfer; holds the request until pready is seen
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) fail_wait();
    rd = prdata;
    slvErr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb
  task automatic wait_log(input int k);
    int n;
    n = 0;
    while (chanLog.size() < k && n < 2000) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 2000) fail_wait();
  endtask : wait_log
  // switches settle through their synchronisers first
  task automatic restart();
    repeat (4) @(posedge core_clk);
    apb(1'b1, ADDR_RESTART, 32'h0000_0001);
    chanLog.delete();
  endtask : restart
  function automatic logic [31:0] map_exp(input int u);
    return {4'h0, 12'(PARM_BASE0 + PARM_STEP * u), 8'h00,
            8'(HOST_BASE0 + HOST_STEP * u)};
  endfunction : map_exp
  function automatic logic [15:0] bcd(input int v);
    return {4'(v / 1000), 4'(v / 100 % 10), 4'(v / 10 % 10), 4'(v % 10)};
  endfunction : bcd

  // ========
  // scenarios
  task automatic t_regs();
    apb(1'b0, ADDR_CTRL, 32'h0000_0000);
    `CHK(rd, CTRL_RST);
    apb(1'b0, ADDR_SHI, 32'h0000_0000);
    `CHK(rd, SHI_RST);
    apb(1'b0, ADDR_MAP, 32'h0000_0000);
    `CHK(rd, map_exp(0));
    apb(1'b0, 8'h30, 32'h0000_0000);
    `CHK(rd, 32'h0000_0000);
    `CHK(slvErr, 1);
  endtask : t_regs
  task automatic t_scan(input logic a, input logic b, input logic f,
                        input int chans);
    int takes;
    takes = f ? 3 : 1;
    cntSwA <= a;
    cntSwB <= b;
    modeSw <= f;
    restart();
    wait_log(8);
    for (int i = 0; i < 8; i++)
      `CHK(chanLog[i], (i / takes) % chans);
  endtask : t_scan
  task automatic t_results();
    t_scan(1'b0, 1'b0, 1'b0, 4);
    `CHK(runLamp, 1);
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, ADDR_RES0 + 8'(4 * i), 32'h0000_0000);
      `CHK(rd, {2'h0, 2'(i), 8'h34});
    end
  endtask : t_results
  task automatic t_scale();
    apb(1'b1, ADDR_CTRL, 32'h0000_0004);
    chanLog.delete();
    // a full filter round of twelve takes, so channel 0 is redone
    wait_log(13);
    apb(1'b0, ADDR_RES0, 32'h0000_0000);
    `CHK(rd, bcd(12'h034));
    apb(1'b0, ADDR_RES1, 32'h0000_0000);
    `CHK(rd, 12'h134);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
  endtask : t_scale
  // model codes 52 and 308; roots on the 4000 scale are 456 and 1109
  task automatic t_proc();
    apb(1'b1, ADDR_CTRL, 32'h0000_1800);
    chanLog.delete();
    wait_log(13);
    apb(1'b0, ADDR_RES0, 32'h0000_0000);
    `CHK(rd, 16'h01c8);
    apb(1'b1, ADDR_CTRL, 32'h0000_0800);
    chanLog.delete();
    wait_log(13);
    apb(1'b0, ADDR_RES1, 32'h0000_0000);
    `CHK(rd, 16'h0455);
    apb(1'b1, ADDR_MEAN, 32'h0000_0003);
    apb(1'b1, ADDR_CTRL, 32'h0000_0080);
    chanLog.delete();
    wait_log(13);
    apb(1'b0, ADDR_RES0, 32'h0000_0000);
    `CHK(rd, 16'h01c8);
    wait_log(110);
    apb(1'b0, ADDR_RES0, 32'h0000_0000);
    `CHK(rd, 16'h0034);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    apb(1'b1, ADDR_MEAN, 32'h0000_0000);
  endtask : t_proc
  task automatic t_wire();
    openIn <= 1'b1;
    t_scan(1'b0, 1'b0, 1'b0, 4);
    `CHK(wireBreakLamp, 1);
    apb(1'b0, ADDR_STAT, 32'h0000_0000);
    `CHK(rd[5:1], 5'h0f);
    rangeSw <= 1'b1;
    t_scan(1'b0, 1'b0, 1'b0, 4);
    `CHK(wireBreakLamp, 0);
    openIn  <= 1'b0;
    rangeSw <= 1'b0;
  endtask : t_wire
  // inhibit waits for the running channel to finish
  task automatic t_inhibit();
    apb(1'b1, ADDR_CTRL, 32'h0000_0001);
    repeat (40) @(posedge core_clk);
    chanLog.delete();
    repeat (100) @(posedge core_clk);
    `CHK({chanLog.size(), adcReq}, 0);
    apb(1'b1, ADDR_CTRL, 32'h0000_0000);
    wait_log(1);
  endtask : t_inhibit
  // the unit switch is taken up only at restart, not while the scan runs
  task automatic t_unit();
    unitSw <= 4'h3;
    repeat (4) @(posedge core_clk);
    apb(1'b0, ADDR_MAP, 32'h0000_0000);
    `CHK(rd, map_exp(0));
    restart();
    repeat (4) @(posedge core_clk);
    apb(1'b0, ADDR_MAP, 32'h0000_0000);
    `CHK(rd, map_exp(3));
  endtask : t_unit
  task automatic t_halt();
    int n;
    stall <= 1'b1;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (runLamp !== 1'b0 && n < 400);
    if (n >= 400) fail_wait();
    `CHK(n > 190 && n < 240, 1);
    `CHK(adcReq, 0);
    stall <= 1'b0;
    restart();
    wait_log(2);
    `CHK(runLamp, 1);
  endtask : t_halt

  // ========
  // main sequence
  initial begin
    {psel, penable, pwrite, paddr, pwdata, unitSw} = '0;
    {cntSwA, cntSwB, rangeSw, modeSw, stall, openIn} = '0;
    reset = 1'b1;
    repeat (12) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    t_regs();
    t_results();
    t_scan(1'b0, 1'b1, 1'b0, 1);
    t_scan(1'b1, 1'b0, 1'b0, 2);
    t_scan(1'b0, 1'b0, 1'b1, 4);
    t_scale();
    t_proc();
    t_wire();
    t_inhibit();
    t_unit();
    t_halt();
    end_sim();
  end
endmodule : analog_input_scan_control_tb_top
`default_nettype wire
